/* File: rtl/rpo_ramped_pulse_output.sv */
// two-port acceleration-controlled pulse train generator
//
// Chosen here: the register offsets and strobed register access.
module rpo_ramped_pulse_output #(
    parameter int unsigned CTRL_PERIOD_CYCLES = rpo_pkg::CTRL_PERIOD_CYC,
    parameter bit          PULSE_CAPABLE      = 1'b1
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire rpo_pkg::rpo_bus_req_t bus,
    output logic [31:0]               rdata,
    input  wire rpo_pkg::rpo_ctx_t     ctx,
    output logic [1:0]                pulse_out,
    output logic [1:0]                dir_out,
    output logic [1:0]                busy_out,
    output logic                      error_flag
);
    import rpo_pkg::*;

    rpo_state_t  s;
    rpo_state_t  n;
    logic        tick;
    logic        cmd_wr;
    logic        sel;
    logic [1:0]  mode;
    rpo_kind_t   kind;
    rpo_port_t   cur;
    logic        port_bad;
    logic        mode_bad;
    logic        tgt_bad;
    logic        switch_bad;
    logic        irq_bad;
    logic        abs_bad;
    logic        ignore;
    logic        bad;
    logic        want_cont;
    logic [31:0] acc;
    logic [31:0] rate32;
    logic [63:0] decel_need;
    logic [63:0] decel_have;

    assign cmd_wr = bus.wr && (bus.addr == OFF_CMD);
    assign sel    = bus.wdata[0];
    assign mode   = bus.wdata[CMD_MODE_LSB +: 2];
    assign kind   = rpo_kind_t'(bus.wdata[CMD_KIND_LSB +: 3]);
    assign cur    = s.port[sel];

    always_comb begin
        n          = s;
        acc        = '0;
        rate32     = '0;
        decel_need = '0;
        decel_have = '0;
        n.rdata    = '0;
        tick       = (s.tick_cnt == 32'(CTRL_PERIOD_CYCLES - 1));
        n.tick_cnt = tick ? '0 : s.tick_cnt + 32'h1;

        // free-running output of each port
        for (int p = 0; p < 2; p++) begin
            rate32 = {16'h0000, s.port[p].rate};
            if (s.port[p].active) begin
                // phase accumulator toggles the pin at twice the frequency
                if (s.port[p].freq != '0) begin
                    acc = s.port[p].phase + {s.port[p].freq[30:0], 1'b0};
                    if (acc >= NCO_WRAP) begin
                        n.port[p].phase = acc - NCO_WRAP;
                        n.port[p].level = ~s.port[p].level;
                        if (!s.port[p].level && !s.port[p].cont &&
                            s.port[p].remain != '0) begin
                            n.port[p].remain = s.port[p].remain - 32'h1;
                        end
                    end else begin
                        n.port[p].phase = acc;
                    end
                end
                // pulses still needed vs pulses a ramp-down would emit
                decel_need = 64'(s.port[p].remain) * 64'(rate32) * DECEL_SCALE;
                decel_have = 64'(s.port[p].freq) * 64'(s.port[p].freq);
                if (!s.port[p].cont && decel_need <= decel_have) begin
                    n.port[p].decel = 1'b1;
                end
                if (tick) begin
                    if (!s.port[p].cont && s.port[p].decel) begin
                        // floor at one step so the count always finishes
                        if (s.port[p].freq > rate32) begin
                            n.port[p].freq = s.port[p].freq - rate32;
                        end
                    end else if (s.port[p].freq < s.port[p].target) begin
                        if (s.port[p].target - s.port[p].freq > rate32) begin
                            n.port[p].freq = s.port[p].freq + rate32;
                        end else begin
                            n.port[p].freq = s.port[p].target;
                        end
                    end else if (s.port[p].freq > s.port[p].target) begin
                        if (s.port[p].freq - s.port[p].target > rate32) begin
                            n.port[p].freq = s.port[p].freq - rate32;
                        end else begin
                            n.port[p].freq = s.port[p].target;
                        end
                    end
                end
                // continuous runs on until a zero target is reached
                if ((!s.port[p].cont && s.port[p].remain == '0) ||
                    (s.port[p].target == '0 && s.port[p].freq == '0)) begin
                    n.port[p].active    = 1'b0;
                    n.port[p].freq      = '0;
                    n.port[p].level     = 1'b0;
                    n.port[p].decel     = 1'b0;
                    n.port[p].zero_stop = 1'b0;
                    n.port[p].hold      = 1'b1;
                end
            end else if (tick) begin
                n.port[p].hold     = 1'b0;
                n.port[p].ini_stop = 1'b0;
            end
        end

        // command checks
        port_bad   = bus.wdata[15:0] > PORT_MAX;
        mode_bad   = mode > MODE_CONT;
        tgt_bad    = s.tgt_reg > TARGET_MAX;
        want_cont  = (mode == MODE_CONT);
        switch_bad = cur.active && (cur.cont != want_cont);
        irq_bad    = bus.wdata[CMD_IRQ_BIT] && ctx.cyclic_busy;
        abs_bad    = !want_cont && bus.wdata[CMD_ABS_BIT] &&
                     !ctx.origin_ok[sel];
        // a zero-target stop in flight and the hold after an immediate stop swallow it
        ignore     = (cur.zero_stop && cur.active) ||
                     (cur.hold && cur.ini_stop);
        bad        = 1'b0;
        case (kind)
            RPO_RAMP: begin
                bad = port_bad || mode_bad || tgt_bad ||
                      s.rate_reg == '0 ||
                      ctx.origin_busy[sel] ||
                      switch_bad || irq_bad || abs_bad;
            end
            RPO_PROFILE: begin
                bad = port_bad || tgt_bad || irq_bad ||
                      s.rate_reg == '0 ||
                      ctx.origin_busy[sel];
            end
            RPO_SPEED: begin
                bad = port_bad || mode_bad || tgt_bad ||
                      ctx.origin_busy[sel] || switch_bad || irq_bad;
            end
            default: begin
                bad = port_bad;
            end
        endcase

        if (bus.wr) begin
            if (cmd_wr) begin
                if (!PULSE_CAPABLE) begin
                    n.err = s.err;
                end else if (kind == RPO_ISTOP) begin
                    if (!port_bad) begin
                        n.port[sel].active = 1'b0;
                        n.port[sel].freq   = '0;
                        n.port[sel].level  = 1'b0;
                        n.port[sel].remain = '0;
                        n.port[sel].hold   = 1'b1;
                        n.port[sel].ini_stop = 1'b1;
                    end
                end else if (ignore) begin
                    n.err = s.err;
                end else if (bad) begin
                    n.err = 1'b1;
                end else begin
                    n.err              = 1'b0;
                    n.port[sel].dir    = bus.wdata[CMD_DIR_BIT];
                    n.port[sel].rate   = s.rate_reg;
                    n.port[sel].target = s.tgt_reg;
                    n.port[sel].hold   = 1'b0;
                    n.port[sel].decel  = 1'b0;
                    n.port[sel].cont   = (kind != RPO_PROFILE) && want_cont;
                    n.port[sel].zero_stop = (kind == RPO_RAMP) &&
                                            cur.active &&
                                            s.tgt_reg == '0;
                    if (!cur.active) begin
                        n.port[sel].freq  = '0;
                        n.port[sel].phase = '0;
                    end
                    if (kind == RPO_SPEED) begin
                        n.port[sel].freq = s.tgt_reg;
                    end
                    if (kind == RPO_PROFILE) begin
                        // profile output may take over a running ramp in any mode, except during a zero-target stop
                        n.port[sel].remain = s.preset_val[sel];
                        n.port[sel].active = s.preset_val[sel] != '0;
                        // a zero count stops a running port: keep the hold
                        n.port[sel].hold   = cur.active &&
                                             s.preset_val[sel] == '0;
                    end else if (want_cont) begin
                        n.port[sel].active = s.tgt_reg != '0 ||
                                             cur.active;
                    end else if (cur.preset_ok) begin
                        // count is used up: a new preset per restart
                        n.port[sel].remain    = s.preset_val[sel];
                        n.port[sel].preset_ok = 1'b0;
                        n.port[sel].active    = 1'b1;
                    end
                end
            end else if (bus.addr == OFF_RATE) begin
                n.rate_reg = bus.wdata[15:0];
            end else if (bus.addr == OFF_TGT_LO) begin
                n.tgt_reg[15:0] = bus.wdata[15:0];
            end else if (bus.addr == OFF_TGT_HI) begin
                n.tgt_reg[31:16] = bus.wdata[15:0];
            end else if (bus.addr == OFF_PRESET0) begin
                n.preset_val[0]        = bus.wdata;
                n.port[0].preset_ok    = 1'b1;
            end else if (bus.addr == OFF_PRESET1) begin
                n.preset_val[1]        = bus.wdata;
                n.port[1].preset_ok    = 1'b1;
            end
        end

        // program mode: no ramp-down, pins drop now
        if (!ctx.run_mode) begin
            for (int p = 0; p < 2; p++) begin
                if (n.port[p].active) begin
                    n.port[p].hold = 1'b1;
                end
                n.port[p].active = 1'b0;
                n.port[p].freq   = '0;
                n.port[p].level  = 1'b0;
            end
        end

        if (bus.rd) begin
            if (bus.addr == OFF_RATE) begin
                n.rdata = {16'h0000, s.rate_reg};
            end else if (bus.addr == OFF_TGT_LO) begin
                n.rdata = {16'h0000, s.tgt_reg[15:0]};
            end else if (bus.addr == OFF_TGT_HI) begin
                n.rdata = {16'h0000, s.tgt_reg[31:16]};
            end else if (bus.addr == OFF_PRESET0) begin
                n.rdata = s.preset_val[0];
            end else if (bus.addr == OFF_PRESET1) begin
                n.rdata = s.preset_val[1];
            end else if (bus.addr == OFF_STATUS) begin
                n.rdata = {23'h000000,
                           s.port[1].zero_stop, s.port[0].zero_stop,
                           s.port[1].cont, s.port[0].cont,
                           s.port[1].active, s.port[0].active,
                           busy_out, s.err};
            end else if (bus.addr == OFF_FREQ0) begin
                n.rdata = s.port[0].freq;
            end else if (bus.addr == OFF_FREQ1) begin
                n.rdata = s.port[1].freq;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s          <= '0;
            s.rate_reg <= RATE_RST;
            s.tgt_reg  <= TGT_RST;
        end else begin
            s <= n;
        end
    end

    assign rdata      = s.rdata;
    assign error_flag = s.err;
    assign pulse_out  = {s.port[1].level, s.port[0].level};
    assign dir_out    = {s.port[1].dir, s.port[0].dir};
    assign busy_out   = {s.port[1].active | s.port[1].hold,
                         s.port[0].active | s.port[0].hold};

    // checks on port 0 (chk_run_halt also covers the port 1 pin)
    logic cmd_ok0;
    assign cmd_ok0 = cmd_wr && bus.wdata[15:0] == 16'h0000 &&
                     PULSE_CAPABLE && ctx.run_mode &&
                     !(s.port[0].zero_stop && s.port[0].active) &&
                     !(s.port[0].hold && s.port[0].ini_stop);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_range_err: assert property (
        cmd_ok0 && kind == RPO_RAMP && s.rate_reg == '0 |=> error_flag)
        else $error("zero rate ramp did not raise error");
    chk_origin_err: assert property (
        cmd_ok0 && kind == RPO_RAMP && ctx.origin_busy[0]
        |=> error_flag && $stable(s.port[0].target))
        else $error("ramp during origin search accepted");
    chk_mode_switch: assert property (
        cmd_ok0 && kind == RPO_RAMP && s.port[0].active &&
        s.port[0].cont != (mode == MODE_CONT) |=> error_flag)
        else $error("mode switch while emitting accepted");
    chk_irq_err: assert property (
        cmd_ok0 && kind == RPO_RAMP && bus.wdata[CMD_IRQ_BIT] &&
        ctx.cyclic_busy |=> error_flag)
        else $error("interrupt ramp during cyclic command accepted");
    chk_err_clear: assert property (
        cmd_ok0 && kind == RPO_RAMP && s.rate_reg != '0 &&
        s.tgt_reg != '0 && s.tgt_reg <= TARGET_MAX &&
        mode == MODE_CONT && !s.port[0].active && !ctx.origin_busy[0] &&
        !bus.wdata[CMD_IRQ_BIT] |=> !error_flag ##1 busy_out[0])
        else $error("good ramp left error set or did not start");
    chk_ramp_step: assert property (
        tick && s.port[0].active && s.port[0].cont && ctx.run_mode &&
        !cmd_wr && s.port[0].freq < s.port[0].target &&
        s.port[0].target - s.port[0].freq > {16'h0000, s.port[0].rate}
        |=> s.port[0].freq ==
            $past(s.port[0].freq) + {16'h0000, $past(s.port[0].rate)})
        else $error("frequency did not step by the rate");
    chk_indep_stop: assert property (
        s.port[0].active && !s.port[0].cont && s.port[0].remain == '0 &&
        !cmd_wr |=> !s.port[0].active && pulse_out[0] == 1'b0)
        else $error("independent output ran past its count");
    chk_zero_keep: assert property (
        cmd_wr && kind == RPO_RAMP && bus.wdata[15:0] == 16'h0000 &&
        s.port[0].zero_stop && s.port[0].active
        |=> s.port[0].target == '0)
        else $error("zero target overwritten during stop");
    chk_run_halt: assert property (
        !ctx.run_mode |=> pulse_out == 2'b00 && s.port[0].freq == '0)
        else $error("output kept running outside run mode");
    chk_hold_flag: assert property (
        $fell(s.port[0].active) |-> busy_out[0])
        else $error("in-progress flag dropped with output");
endmodule

/* File: rtl/rpo_pkg.sv */
// shared constants, command fields and state types of the ramped pulse output
package rpo_pkg;

    // timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CTRL_PERIOD_MS  = 4;
    localparam int unsigned CTRL_PERIOD_CYC = CLK_HZ / 1000 * CTRL_PERIOD_MS;
    localparam logic [31:0] NCO_WRAP        = 32'(CLK_HZ);
    localparam logic [63:0] DECEL_SCALE     = 64'(2 * 1000 / CTRL_PERIOD_MS);

    // settings limits
    localparam logic [31:0] TARGET_MAX = 32'h000186A0;
    localparam logic [15:0] PORT_MAX   = 16'h0001;
    localparam logic [1:0]  MODE_INDEP = 2'h0;
    localparam logic [1:0]  MODE_CONT  = 2'h1;

    // register offsets
    localparam logic [7:0] OFF_CMD     = 8'h00;
    localparam logic [7:0] OFF_RATE    = 8'h04;
    localparam logic [7:0] OFF_TGT_LO  = 8'h08;
    localparam logic [7:0] OFF_TGT_HI  = 8'h0C;
    localparam logic [7:0] OFF_PRESET0 = 8'h10;
    localparam logic [7:0] OFF_PRESET1 = 8'h14;
    localparam logic [7:0] OFF_STATUS  = 8'h18;
    localparam logic [7:0] OFF_FREQ0   = 8'h1C;
    localparam logic [7:0] OFF_FREQ1   = 8'h20;

    // command word fields
    localparam int CMD_MODE_LSB = 16;
    localparam int CMD_DIR_BIT  = 18;
    localparam int CMD_ABS_BIT  = 19;
    localparam int CMD_IRQ_BIT  = 20;
    localparam int CMD_KIND_LSB = 24;

    // values after reset
    localparam logic [15:0] RATE_RST = 16'h0000;
    localparam logic [31:0] TGT_RST  = 32'h00000000;

    typedef enum logic [2:0] {
        RPO_RAMP,
        RPO_PROFILE,
        RPO_SPEED,
        RPO_ISTOP
    } rpo_kind_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rpo_bus_req_t;

    typedef struct packed {
        logic       run_mode;
        logic       cyclic_busy;
        logic [1:0] origin_busy;
        logic [1:0] origin_ok;
    } rpo_ctx_t;

    typedef struct packed {
        logic        active;
        logic        cont;
        logic        dir;
        logic        preset_ok;
        logic        zero_stop;
        logic        ini_stop;
        logic        hold;
        logic        decel;
        logic        level;
        logic [15:0] rate;
        logic [31:0] freq;
        logic [31:0] target;
        logic [31:0] remain;
        logic [31:0] phase;
    } rpo_port_t;

    typedef struct packed {
        rpo_port_t [1:0]   port;
        logic              err;
        logic [31:0]       tick_cnt;
        logic [15:0]       rate_reg;
        logic [31:0]       tgt_reg;
        logic [1:0][31:0]  preset_val;
        logic [31:0]       rdata;
    } rpo_state_t;

endpackage

/* File: tb/rpo_motor_drive.sv */
// motor drive model: counts steps on both pulse outputs
module rpo_motor_drive (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  pulse_out,
    input  wire logic [1:0]  dir_out,
    output logic      [31:0] steps0,
    output logic      [31:0] steps1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last;
    // a step is taken on each rising pulse edge, signed by direction
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            last   <= 2'h0;
            steps0 <= 32'h0;
            steps1 <= 32'h0;
        end else begin
            last <= pulse_out;
            if (pulse_out[0] && !last[0]) begin
                steps0 <= dir_out[0] ? steps0 - 32'h1 : steps0 + 32'h1;
            end
            if (pulse_out[1] && !last[1]) begin
                steps1 <= dir_out[1] ? steps1 - 32'h1 : steps1 + 32'h1;
            end
        end
    end
endmodule

/* File: tb/tb_ramped_pulse_output.sv */
// self-checking bench for the ramped pulse output
module tb_ramped_pulse_output;
    timeunit 1ns;
    timeprecision 1ps;
    import rpo_pkg::*;
    logic         sys_clk;
    logic         rst_b;
    logic         error_flag;
    rpo_bus_req_t bus;
    rpo_ctx_t     ctx;
    logic [31:0]  rdata;
    logic [31:0]  steps0;
    logic [31:0]  steps1;
    logic [31:0]  v;
    logic [31:0]  s;
    logic [1:0]   pulse_out;
    logic [1:0]   dir_out;
    logic [1:0]   busy_out;
    logic [1:0]   nop_busy;
    logic         nop_err;
    int           errors;
    int           compares;

    // short control period keeps the run brief
    rpo_ramped_pulse_output #(.CTRL_PERIOD_CYCLES(200)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .ctx(ctx), .pulse_out(pulse_out), .dir_out(dir_out),
        .busy_out(busy_out), .error_flag(error_flag));
    rpo_motor_drive drive (
        .sys_clk(sys_clk), .rst_b(rst_b), .pulse_out(pulse_out),
        .dir_out(dir_out), .steps0(steps0), .steps1(steps1));
    // variant without pulse outputs sees the same commands
    rpo_ramped_pulse_output #(.CTRL_PERIOD_CYCLES(200),
        .PULSE_CAPABLE(1'b0)) dut_nop (
        .sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rdata(),
        .ctx(ctx), .pulse_out(), .dir_out(),
        .busy_out(nop_busy), .error_flag(nop_err));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    // f holds direction, absolute and interrupt-task bits in that order
    function automatic logic [31:0] cmd(input logic [2:0] k,
        input logic [2:0] f, input logic [1:0] m, input logic [15:0] p);
        return ({29'h0, k} << CMD_KIND_LSB) | ({29'h0, f} << CMD_DIR_BIT)
             | ({30'h0, m} << CMD_MODE_LSB) | {16'h0, p};
    endfunction
    // target is written low word first, command last
    task automatic go(input logic [31:0] c, input logic [15:0] r,
                      input logic [31:0] t);
        wr(OFF_RATE, {16'h0, r});
        wr(OFF_TGT_LO, {16'h0, t[15:0]});
        wr(OFF_TGT_HI, {16'h0, t[31:16]});
        wr(OFF_CMD, c);
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_idle(input int p, input int n);
        for (int i = 0; i <= n; i++) begin
            @(posedge sys_clk);
            #1;
            if (busy_out[p] === 1'b0) return;
        end
        errors++;
        $display("Error at %0t: seen %h expected %h", $time, busy_out, 2'h0);
        results();
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic t_refuse();
        logic [31:0] c;
        logic [31:0] t;
        logic [15:0] r;
        rd(8'hFC);
        chk(v, 32'h0);
        for (int i = 0; i < 7; i++) begin
            go(cmd(3'h0, 3'h0, MODE_INDEP, 16'h0), 16'h4E20, TARGET_MAX);
            chk(32'(error_flag), 32'h0);
            c = cmd(3'h0, i == 5 ? 3'h2 : i == 6 ? 3'h4 : 3'h0,
                    i == 1 ? 2'h2 : MODE_INDEP, i == 0 ? 16'h2 : 16'h0);
            r = i == 2 ? 16'h0 : 16'h4E20;
            t = i == 3 ? TARGET_MAX + 32'h1 : TARGET_MAX;
            @(posedge sys_clk);
            ctx <= '{1'b1, i == 6, i == 4 ? 2'h1 : 2'h0,
                     i == 5 ? 2'h0 : 2'h3};
            go(c, r, t);
            chk(32'(error_flag), 32'h1);
            @(posedge sys_clk);
            ctx <= '{1'b1, 1'b0, 2'h0, 2'h3};
        end
    endtask
    task automatic t_ramp();
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        chk(32'(busy_out[0]), 32'h1);
        cycles(250);
        rd(OFF_FREQ0);
        s = v;
        // reads sit exactly one control period apart
        cycles(198);
        rd(OFF_FREQ0);
        chk(v - s, 32'h4E20);
        cycles(1200);
        rd(OFF_FREQ0);
        chk(v, TARGET_MAX);
        s = steps0;
        cycles(3000);
        chk(32'(steps0 - s >= 32'h2), 32'h1);
    endtask
    task automatic t_modes();
        go(cmd(3'h0, 3'h0, MODE_INDEP, 16'h0), 16'h4E20, TARGET_MAX);
        chk(32'(error_flag), 32'h1);
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        chk(32'(error_flag), 32'h0);
        go(cmd(3'h1, 3'h0, MODE_CONT, 16'h0), 16'h0, TARGET_MAX);
        chk(32'(error_flag), 32'h1);
        chk({29'h0, nop_err, nop_busy}, 32'h0);
    endtask
    task automatic t_halt();
        @(posedge sys_clk);
        ctx.run_mode <= 1'b0;
        cycles(3);
        s = steps0;
        cycles(2000);
        chk(steps0 - s, 32'h0);
        chk(32'(pulse_out[0]), 32'h0);
        ctx.run_mode <= 1'b1;
        wait_idle(0, 400);
    endtask
    task automatic t_zero();
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        cycles(1400);
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, 32'h0);
        // a later command must not lift the zero target
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        wait_idle(0, 1600);
        rd(OFF_FREQ0);
        chk(v, 32'h0);
    endtask
    task automatic t_count();
        s = steps1;
        go(cmd(3'h0, 3'h0, MODE_INDEP, 16'h1), 16'hFFFF, TARGET_MAX);
        cycles(2000);
        chk(steps1 - s, 32'h0);
        wr(OFF_PRESET1, 32'hA);
        // reverse direction: the drive counts ten steps down
        go(cmd(3'h0, 3'h1, MODE_INDEP, 16'h1), 16'hFFFF, TARGET_MAX);
        wait_idle(1, 30000);
        chk(steps1 - s, 32'hFFFFFFF6);
    endtask
    task automatic t_restart();
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        wr(OFF_CMD, cmd(3'h3, 3'h0, MODE_CONT, 16'h0));
        // hold ends on a tick, so the next tick is at most 200 cycles away
        wait_idle(0, 400);
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        chk(32'(busy_out[0]), 32'h1);
        wr(OFF_CMD, cmd(3'h3, 3'h0, MODE_CONT, 16'h0));
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        rd(OFF_STATUS);
        chk({30'h0, busy_out[0], v[3]}, 32'h2);
        wait_idle(0, 400);
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        chk(32'(busy_out[0]), 32'h1);
        // zero target from standstill stops at once, leaving the hold
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, 32'h0);
        go(cmd(3'h0, 3'h0, MODE_CONT, 16'h0), 16'h4E20, TARGET_MAX);
        rd(OFF_STATUS);
        chk(32'(v[3]), 32'h1);
        s = steps0;
        wr(OFF_PRESET0, 32'h4);
        go(cmd(3'h1, 3'h0, MODE_INDEP, 16'h0), 16'hFFFF, TARGET_MAX);
        chk(32'(error_flag), 32'h0);
        go(cmd(3'h0, 3'h0, MODE_INDEP, 16'h0), 16'hFFFF, TARGET_MAX);
        chk(32'(error_flag), 32'h0);
        wait_idle(0, 8000);
        chk(steps0 - s, 32'h4);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        errors = 0;
        compares = 0;
        bus = '0;
        ctx = '{1'b1, 1'b0, 2'h0, 2'h3};
        rst_b = 1'b0;
        cycles(6);
        #1 chk({27'h0, error_flag, busy_out, pulse_out}, 32'h0);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        t_refuse();
        t_ramp();
        t_modes();
        t_halt();
        t_zero();
        t_count();
        t_restart();
        results();
    end
endmodule
